// ---- rtl/rgr_ldo_mode.sv ----
`timescale 1ns/1ps
module rgr_ldo_mode
	import rgr_pkg::*;
(
	// regulator control fields and low-power mode
	input wire logic enable,
	input wire logic sleep_off,
	input wire logic low_power,
	// resulting power state
	output rgr_pwr_t state
);
	always_comb begin
		if (!enable) begin
			state = RGR_PWR_OFF;
		end else if (!low_power) begin
			state = RGR_PWR_FULL;
		end else if (sleep_off) begin
			state = RGR_PWR_OFF;
		end else begin
			state = RGR_PWR_REDUCED;
		end
	end
endmodule

// ---- rtl/rgr_pin_sync.sv ----
`timescale 1ns/1ps
module rgr_pin_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// pins in, stable level out
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] pin_level
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
	logic [WIDTH-1:0] lvl_next;

	// a change counts once stages two and three agree
	always_comb begin
		lvl_next = lvl_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				lvl_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			lvl_reg <= '0;
		end else begin
			s1_reg <= pin_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign pin_level = lvl_reg;
endmodule

// ---- rtl/rgr_pkg.sv ----
// Overview of operation
// - regulator control resets to 0x88: both regulators on, other fields zero
// - bit 7 enables second regulator, bit 6 is its sleep-off flag
// - enabled regulator: full power normally; low-power: reduced if flag 0, off if 1
// - bits 5:4 pick second regulator voltage: 1.8, 2.5, 3.0, 3.3 V
// - voltage select taken only while disabled or in the disabling write
// - bit 3 enables first regulator, bit 2 is its sleep-off flag
// - bits 1:0 pick first regulator voltage: external, 2.5, 2.75, 3.0 V
// - pin config bits 7:4 pick edge per pin: 0 falling, 1 rising
// - pin config bits 3:0 mask per pin interrupt; set bit suppresses
// - pin config and direction/value registers reset to 0x00
// - direction/value bits 7:4 select direction: 0 input, 1 output
// - output pin: value 1 pulls low, value 0 releases to pull-up
// - input pin: value bit reflects the pin level
// - writes to value bits of input pins are ignored
// - low-power mode when pin high, pin enable set and supply select set
package rgr_pkg;
	localparam logic [7:0] RGR_ADDR_REG_CTRL = 8'h0e;
	localparam logic [7:0] RGR_ADDR_PIN_CFG = 8'h0f;
	localparam logic [7:0] RGR_ADDR_PIN_DIRVAL = 8'h10;
	localparam logic [7:0] RGR_RST_REG_CTRL = 8'h88;
	localparam logic [7:0] RGR_RST_PIN_CFG = 8'h00;
	localparam logic [7:0] RGR_RST_PIN_DIRVAL = 8'h00;
	localparam int RGR_SECOND_EN_BIT = 7;
	localparam int RGR_SECOND_SLP_BIT = 6;
	localparam int RGR_SECOND_VSEL_LO = 4;
	localparam int RGR_FIRST_EN_BIT = 3;
	localparam int RGR_FIRST_SLP_BIT = 2;
	localparam int RGR_FIRST_VSEL_LO = 0;
	localparam int RGR_EDGE_LO = 4;
	localparam int RGR_MASK_LO = 0;
	localparam int RGR_DIR_LO = 4;
	localparam int RGR_VAL_LO = 0;
	localparam int RGR_PINS = 4;
	typedef enum logic [1:0] {
		RGR_PWR_OFF,
		RGR_PWR_REDUCED,
		RGR_PWR_FULL
	} rgr_pwr_t;
endpackage

// ---- rtl/rgr_regs.sv ----
`timescale 1ns/1ps
module rgr_regs
	import rgr_pkg::*;
#(
	parameter int PINS = RGR_PINS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register access from the serial engine
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic rd_valid,
	// low-power request
	input wire logic low_power_request_pin,
	input wire logic low_power_pin_enable,
	input wire logic supply_mode_select,
	output logic low_power_mode,
	// regulator controls
	output logic second_reg_enable,
	output logic second_reg_sleep_off,
	output logic [1:0] second_reg_voltage_sel,
	output logic first_reg_enable,
	output logic first_reg_sleep_off,
	output logic [1:0] first_reg_voltage_sel,
	output logic [1:0] second_reg_power,
	output logic [1:0] first_reg_power,
	// open-drain pins
	input wire logic [PINS-1:0] gpio_in,
	output logic [PINS-1:0] gpio_out,
	output logic [PINS-1:0] gpio_oe,
	// pin interrupt event
	output logic [PINS-1:0] pin_event
);
	////////////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] cfg_reg, cfg_next;
	logic [PINS-1:0] dir_reg, dir_next;
	logic [PINS-1:0] oval_reg, oval_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	logic [PINS-1:0] lvl_d_reg, lvl_d_next;
	logic [PINS-1:0] evt_reg, evt_next;
	logic [PINS-1:0] oe_reg, oe_next;
	logic lp_reg, lp_next;
	logic [1:0] pw2_reg, pw1_reg;
	logic [PINS-1:0] pin_level;
	logic lp_pin_level;
	rgr_pwr_t pw2_state, pw1_state;
	logic [PINS:0] sync_level;

	// pins and the low-power request come from outside the clock domain
	rgr_pin_sync #(.WIDTH(PINS + 1)) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_async({low_power_request_pin, gpio_in}),
		.pin_level(sync_level)
	);
	// one vector out of the synchroniser, split here rather than at the port
	assign pin_level = sync_level[PINS-1:0];
	assign lp_pin_level = sync_level[PINS];

	////////////////////////////////////////////////////////////////////////////////
	// register writes
	always_comb begin
		ctrl_next = ctrl_reg;
		cfg_next = cfg_reg;
		dir_next = dir_reg;
		oval_next = oval_reg;
		if (wr_en && addr == RGR_ADDR_REG_CTRL) begin
			ctrl_next[RGR_SECOND_EN_BIT] = wr_data[RGR_SECOND_EN_BIT];
			ctrl_next[RGR_SECOND_SLP_BIT] = wr_data[RGR_SECOND_SLP_BIT];
			ctrl_next[RGR_FIRST_EN_BIT] = wr_data[RGR_FIRST_EN_BIT];
			ctrl_next[RGR_FIRST_SLP_BIT] = wr_data[RGR_FIRST_SLP_BIT];
			// a live regulator never sees its voltage step under it
			if (!ctrl_reg[RGR_SECOND_EN_BIT] || !wr_data[RGR_SECOND_EN_BIT]) begin
				ctrl_next[RGR_SECOND_VSEL_LO +: 2] = wr_data[RGR_SECOND_VSEL_LO +: 2];
			end
			if (!ctrl_reg[RGR_FIRST_EN_BIT] || !wr_data[RGR_FIRST_EN_BIT]) begin
				ctrl_next[RGR_FIRST_VSEL_LO +: 2] = wr_data[RGR_FIRST_VSEL_LO +: 2];
			end
		end
		if (wr_en && addr == RGR_ADDR_PIN_CFG) begin
			cfg_next = wr_data;
		end
		if (wr_en && addr == RGR_ADDR_PIN_DIRVAL) begin
			dir_next = wr_data[RGR_DIR_LO +: PINS];
			for (int i = 0; i < PINS; i++) begin
				if (dir_reg[i]) begin
					oval_next[i] = wr_data[RGR_VAL_LO + i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pins, events, reads and low-power mode
	always_comb begin
		oe_next = dir_reg & oval_reg;
		lvl_d_next = pin_level;
		for (int i = 0; i < PINS; i++) begin
			evt_next[i] = !dir_reg[i] && !cfg_reg[RGR_MASK_LO + i]
				&& (cfg_reg[RGR_EDGE_LO + i] ? (pin_level[i] && !lvl_d_reg[i])
				: (!pin_level[i] && lvl_d_reg[i]));
		end
		lp_next = lp_pin_level && low_power_pin_enable && supply_mode_select;
		rd_valid_next = rd_en;
		rd_data_next = 8'h00;
		if (rd_en) begin
			unique case (addr)
				RGR_ADDR_REG_CTRL: rd_data_next = ctrl_reg;
				RGR_ADDR_PIN_CFG: rd_data_next = cfg_reg;
				RGR_ADDR_PIN_DIRVAL: begin
					rd_data_next[RGR_DIR_LO +: PINS] = dir_reg;
					rd_data_next[RGR_VAL_LO +: PINS] = (dir_reg & oval_reg)
						| (~dir_reg & pin_level);
				end
				default: rd_data_next = 8'h00;
			endcase
		end
	end

	rgr_ldo_mode u_mode2 (
		.enable(ctrl_reg[RGR_SECOND_EN_BIT]),
		.sleep_off(ctrl_reg[RGR_SECOND_SLP_BIT]),
		.low_power(lp_reg),
		.state(pw2_state)
	);
	rgr_ldo_mode u_mode1 (
		.enable(ctrl_reg[RGR_FIRST_EN_BIT]),
		.sleep_off(ctrl_reg[RGR_FIRST_SLP_BIT]),
		.low_power(lp_reg),
		.state(pw1_state)
	);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl_reg <= RGR_RST_REG_CTRL;
			cfg_reg <= RGR_RST_PIN_CFG;
			dir_reg <= RGR_RST_PIN_DIRVAL[RGR_DIR_LO +: PINS];
			oval_reg <= RGR_RST_PIN_DIRVAL[RGR_VAL_LO +: PINS];
			rd_data_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
			lvl_d_reg <= '0;
			evt_reg <= '0;
			oe_reg <= '0;
			lp_reg <= 1'b0;
			pw2_reg <= 2'h0;
			pw1_reg <= 2'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			cfg_reg <= cfg_next;
			dir_reg <= dir_next;
			oval_reg <= oval_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			lvl_d_reg <= lvl_d_next;
			evt_reg <= evt_next;
			oe_reg <= oe_next;
			lp_reg <= lp_next;
			pw2_reg <= pw2_state;
			pw1_reg <= pw1_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from flops, except gpio_out tied low
	assign second_reg_enable = ctrl_reg[RGR_SECOND_EN_BIT];
	assign second_reg_sleep_off = ctrl_reg[RGR_SECOND_SLP_BIT];
	assign second_reg_voltage_sel = ctrl_reg[RGR_SECOND_VSEL_LO +: 2];
	assign first_reg_enable = ctrl_reg[RGR_FIRST_EN_BIT];
	assign first_reg_sleep_off = ctrl_reg[RGR_FIRST_SLP_BIT];
	assign first_reg_voltage_sel = ctrl_reg[RGR_FIRST_VSEL_LO +: 2];
	assign second_reg_power = pw2_reg;
	assign first_reg_power = pw1_reg;
	assign gpio_out = '0; // open drain only ever pulls low
	assign gpio_oe = oe_reg;
	assign pin_event = evt_reg;
	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;
	assign low_power_mode = lp_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_ctrl_reset: assert property (@(posedge sys_clk)
		$past(reset) |-> ctrl_reg == RGR_RST_REG_CTRL) else $error("ctrl reset value wrong");
	a_vsel_hold: assert property (@(posedge sys_clk) disable iff (reset)
		$past(ctrl_reg[7]) && ctrl_reg[7] |-> $stable(ctrl_reg[5:4]))
		else $error("second voltage changed while enabled");
	a_vsel1_hold: assert property (@(posedge sys_clk) disable iff (reset)
		$past(ctrl_reg[3]) && ctrl_reg[3] |-> $stable(ctrl_reg[1:0]))
		else $error("first voltage changed while enabled");
	a_ctrl_update: assert property (@(posedge sys_clk) disable iff (reset)
		wr_en && addr == 8'h0e |=> ctrl_reg[7] == $past(wr_data[7])
		&& ctrl_reg[2] == $past(wr_data[2])) else $error("ctrl write not taken");
	a_pw_off: assert property (@(posedge sys_clk) disable iff (reset)
		!ctrl_reg[7] |=> pw2_reg == 2'(RGR_PWR_OFF)) else $error("disabled reg not off");
	a_pw_sleep: assert property (@(posedge sys_clk) disable iff (reset)
		ctrl_reg[3] && lp_reg && !ctrl_reg[2] |=> pw1_reg == 2'(RGR_PWR_REDUCED))
		else $error("reduced power not chosen");
	a_pw_full: assert property (@(posedge sys_clk) disable iff (reset)
		ctrl_reg[3] && !lp_reg |=> pw1_reg == 2'(RGR_PWR_FULL)) else $error("full power missing");
	a_od_drive: assert property (@(posedge sys_clk) disable iff (reset)
		dir_reg[0] && oval_reg[0] |=> gpio_oe[0]) else $error("pull-down not driven");
	a_od_input: assert property (@(posedge sys_clk) disable iff (reset)
		!dir_reg[1] |=> !gpio_oe[1]) else $error("input pin driven");
	a_val_ignore: assert property (@(posedge sys_clk) disable iff (reset)
		wr_en && addr == 8'h10 && !dir_reg[2] |=> oval_reg[2] == $past(oval_reg[2]))
		else $error("input value written");
	a_cfg_reset: assert property (@(posedge sys_clk)
		$past(reset) |-> cfg_reg == 8'h00 && dir_reg == 4'h0) else $error("pin reset wrong");
	a_evt_mask: assert property (@(posedge sys_clk) disable iff (reset)
		cfg_reg[0] |=> !pin_event[0]) else $error("masked event raised");
	a_evt_dir: assert property (@(posedge sys_clk) disable iff (reset)
		dir_reg[3] |=> !pin_event[3]) else $error("output pin raised event");
	a_evt_rise: assert property (@(posedge sys_clk) disable iff (reset)
		!dir_reg[0] && !cfg_reg[0] && cfg_reg[4] && pin_level[0] && !lvl_d_reg[0]
		|=> pin_event[0]) else $error("rising edge missed");
	a_lp_mode: assert property (@(posedge sys_clk) disable iff (reset)
		!low_power_pin_enable |=> !low_power_mode) else $error("low power without enable");
	a_rd_input: assert property (@(posedge sys_clk) disable iff (reset)
		rd_en && addr == 8'h10 && !dir_reg[1] |=> rd_data[1] == $past(pin_level[1]))
		else $error("input level not read");
	a_vsel_code: assert property (@(posedge sys_clk) disable iff (reset)
		wr_en && addr == 8'h0e && !ctrl_reg[7] |=> second_reg_voltage_sel == $past(wr_data[5:4]))
		else $error("voltage code lost");
	a_vsel1_code: assert property (@(posedge sys_clk) disable iff (reset)
		wr_en && addr == 8'h0e && !ctrl_reg[3] |=> first_reg_voltage_sel == $past(wr_data[1:0]))
		else $error("first voltage code lost");
	a_pw2_full: assert property (@(posedge sys_clk) disable iff (reset)
		ctrl_reg[7] && !lp_reg |=> pw2_reg == 2'(RGR_PWR_FULL))
		else $error("second full power missing");
	a_pw2_sleep: assert property (@(posedge sys_clk) disable iff (reset)
		ctrl_reg[7] && lp_reg && !ctrl_reg[6] |=> pw2_reg == 2'(RGR_PWR_REDUCED))
		else $error("second reduced power not chosen");
	a_pw2_sleep_off: assert property (@(posedge sys_clk) disable iff (reset)
		ctrl_reg[7] && lp_reg && ctrl_reg[6] |=> pw2_reg == 2'(RGR_PWR_OFF))
		else $error("second not off in low power");
	a_pw1_off: assert property (@(posedge sys_clk) disable iff (reset)
		!ctrl_reg[3] |=> pw1_reg == 2'(RGR_PWR_OFF)) else $error("disabled first not off");
	a_sleep_update: assert property (@(posedge sys_clk) disable iff (reset)
		wr_en && addr == RGR_ADDR_REG_CTRL |=> second_reg_sleep_off == $past(wr_data[6])
		&& first_reg_sleep_off == $past(wr_data[2]) && first_reg_enable == $past(wr_data[3]))
		else $error("sleep-off write not taken");
	a_cfg_write: assert property (@(posedge sys_clk) disable iff (reset)
		wr_en && addr == RGR_ADDR_PIN_CFG |=> cfg_reg == $past(wr_data))
		else $error("pin config write not taken");
	a_dir_write: assert property (@(posedge sys_clk) disable iff (reset)
		wr_en && addr == RGR_ADDR_PIN_DIRVAL |=> dir_reg == $past(wr_data[7:4]))
		else $error("direction write not taken");
	a_od_release: assert property (@(posedge sys_clk) disable iff (reset)
		dir_reg[2] && !oval_reg[2] |=> !gpio_oe[2]) else $error("released pin driven");
	a_evt_fall: assert property (@(posedge sys_clk) disable iff (reset)
		!dir_reg[1] && !cfg_reg[1] && !cfg_reg[5] && !pin_level[1] && lvl_d_reg[1]
		|=> pin_event[1]) else $error("falling edge missed");
	a_lp_on: assert property (@(posedge sys_clk) disable iff (reset)
		lp_pin_level && low_power_pin_enable && supply_mode_select |=> low_power_mode)
		else $error("low power not entered");

	// refused voltage step on a live regulator
	c_vsel_refused: cover property (@(posedge sys_clk) wr_en && addr == RGR_ADDR_REG_CTRL
		&& ctrl_reg[7] && wr_data[7] && wr_data[5:4] != ctrl_reg[5:4]);
	c_enable_write: cover property (@(posedge sys_clk) wr_en && addr == 8'h0e && !ctrl_reg[7]);
	c_low_power: cover property (@(posedge sys_clk) lp_reg && pw2_reg == 2'(RGR_PWR_REDUCED));
	c_pin_event: cover property (@(posedge sys_clk) |pin_event);
	c_drive_low: cover property (@(posedge sys_clk) |gpio_oe);
endmodule

// ---- test/regulator_and_gpio_regs_test.sv ----
`timescale 1ns/1ps
module regulator_and_gpio_regs_test;
	import rgr_pkg::*;
	logic sys_clk, reset, wr_en, rd_en, rd_valid, low_power_mode;
	logic [7:0] addr, wr_data, rd_data, v;
	logic low_power_request_pin, low_power_pin_enable, supply_mode_select;
	logic second_reg_enable, second_reg_sleep_off, first_reg_enable, first_reg_sleep_off;
	logic [1:0] second_reg_voltage_sel, first_reg_voltage_sel, second_reg_power, first_reg_power;
	logic [3:0] gpio_in, gpio_out, gpio_oe, pin_event, ext_en, ext_val;
	int n_errors, cmp_count, cycles;
	rgr_regs DUT (.sys_clk, .reset, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid,
		.low_power_request_pin, .low_power_pin_enable, .supply_mode_select, .low_power_mode,
		.second_reg_enable, .second_reg_sleep_off, .second_reg_voltage_sel, .first_reg_enable,
		.first_reg_sleep_off, .first_reg_voltage_sel, .second_reg_power, .first_reg_power,
		.gpio_in, .gpio_out, .gpio_oe, .pin_event);
	rgr_pin_model board (.gpio_oe(gpio_oe), .ext_en(ext_en), .ext_val(ext_val),
		.pin_level(gpio_in));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		chk("rd_valid", 8'h01, {7'h00, rd_valid});
		chk("rd_data", e, rd_data);
	endtask
	task automatic pwr(input logic [1:0] es, input logic [1:0] ef);
		chk("second_reg_power", {6'h00, es}, {6'h00, second_reg_power});
		chk("first_reg_power", {6'h00, ef}, {6'h00, first_reg_power});
	endtask
	// pin sync plus registered mode output needs a few cycles to settle
	task automatic lp(input logic [2:0] s, input logic e);
		@(posedge sys_clk);
		low_power_request_pin <= s[2];
		low_power_pin_enable <= s[1];
		supply_mode_select <= s[0];
		repeat (8) @(posedge sys_clk);
		#1;
		chk("low_power_mode", {7'h00, e}, {7'h00, low_power_mode});
	endtask
	task automatic edge_cnt(input int p, input logic lv, input int exp);
		int n;
		n = 0;
		@(posedge sys_clk);
		ext_val[p] <= lv;
		repeat (10) begin
			@(posedge sys_clk);
			#1;
			if (pin_event[p] === 1'b1) n++;
		end
		chk("pin_event", exp[7:0], n[7:0]);
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		{wr_en, rd_en, addr, wr_data} = 18'h00000;
		{low_power_request_pin, low_power_pin_enable, supply_mode_select} = 3'h0;
		ext_en = 4'hf;
		ext_val = 4'h0;
		n_errors = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		chk("second_reg_enable", 8'h01, {7'h00, second_reg_enable});
		rd(RGR_ADDR_REG_CTRL, RGR_RST_REG_CTRL);
		rd(RGR_ADDR_PIN_CFG, RGR_RST_PIN_CFG);
		rd(RGR_ADDR_PIN_DIRVAL, RGR_RST_PIN_DIRVAL);
		rd(8'h11, 8'h00);
		pwr(RGR_PWR_FULL, RGR_PWR_FULL);
		// voltage change while staying enabled is dropped
		wr(RGR_ADDR_REG_CTRL, 8'hb9);
		rd(RGR_ADDR_REG_CTRL, 8'h88);
		for (int c = 0; c < 4; c++) begin
			wr(RGR_ADDR_REG_CTRL, 8'h00);
			rd(RGR_ADDR_REG_CTRL, 8'h00);
			pwr(RGR_PWR_OFF, RGR_PWR_OFF);
			v = {2'b10, c[1:0], 2'b10, c[1:0]};
			wr(RGR_ADDR_REG_CTRL, v);
			chk("second_reg_voltage_sel", {6'h00, v[5:4]}, {6'h00, second_reg_voltage_sel});
			chk("first_reg_voltage_sel", {6'h00, v[1:0]}, {6'h00, first_reg_voltage_sel});
			chk("first_reg_enable", 8'h01, {7'h00, first_reg_enable});
			rd(RGR_ADDR_REG_CTRL, v);
		end
		wr(RGR_ADDR_REG_CTRL, 8'hc8);
		chk("second_reg_sleep_off", 8'h01, {7'h00, second_reg_sleep_off});
		chk("first_reg_sleep_off", 8'h00, {7'h00, first_reg_sleep_off});
		lp(3'b111, 1'b1);
		pwr(RGR_PWR_OFF, RGR_PWR_REDUCED);
		wr(RGR_ADDR_REG_CTRL, 8'h8c);
		chk("first_reg_sleep_off", 8'h01, {7'h00, first_reg_sleep_off});
		lp(3'b111, 1'b1);
		pwr(RGR_PWR_REDUCED, RGR_PWR_OFF);
		lp(3'b110, 1'b0);
		lp(3'b101, 1'b0);
		lp(3'b011, 1'b0);
		pwr(RGR_PWR_FULL, RGR_PWR_FULL);
		wr(RGR_ADDR_REG_CTRL, 8'h44);
		lp(3'b111, 1'b1);
		pwr(RGR_PWR_OFF, RGR_PWR_OFF);
		lp(3'b000, 1'b0);
		// pins
		// value bits of pins that are still inputs during the write are dropped
		wr(RGR_ADDR_PIN_DIRVAL, 8'hf5);
		rd(RGR_ADDR_PIN_DIRVAL, 8'hf0);
		wr(RGR_ADDR_PIN_DIRVAL, 8'hf5);
		rd(RGR_ADDR_PIN_DIRVAL, 8'hf5);
		chk("gpio_oe", 8'h05, {4'h0, gpio_oe});
		chk("gpio_out", 8'h00, {4'h0, gpio_out});
		@(posedge sys_clk);
		ext_val <= 4'h4;
		wr(RGR_ADDR_PIN_DIRVAL, 8'h3f);
		repeat (6) @(posedge sys_clk);
		rd(RGR_ADDR_PIN_DIRVAL, 8'h37);
		chk("gpio_oe", 8'h03, {4'h0, gpio_oe});
		// released line must read as the pull-up level
		@(posedge sys_clk);
		ext_en <= 4'h7;
		repeat (6) @(posedge sys_clk);
		rd(RGR_ADDR_PIN_DIRVAL, 8'h3f);
		wr(RGR_ADDR_PIN_DIRVAL, 8'h00);
		edge_cnt(0, 1'b1, 0);
		edge_cnt(0, 1'b0, 1);
		wr(RGR_ADDR_PIN_CFG, 8'h10);
		edge_cnt(0, 1'b1, 1);
		edge_cnt(0, 1'b0, 0);
		wr(RGR_ADDR_PIN_CFG, 8'h11);
		edge_cnt(0, 1'b1, 0);
		wr(RGR_ADDR_PIN_CFG, 8'h20);
		wr(RGR_ADDR_PIN_DIRVAL, 8'h20);
		edge_cnt(1, 1'b1, 0);
		stop_test();
	end
endmodule

// ---- test/rgr_pin_model.sv ----
`timescale 1ns/1ps
module rgr_pin_model (
	// device pull-down enables
	input wire logic [3:0] gpio_oe,
	// external drivers on the board
	input wire logic [3:0] ext_en,
	input wire logic [3:0] ext_val,
	// resolved pin level
	output logic [3:0] pin_level
);
	////////////////////////////////////////////////////////////////////////
	// wired-and: any pull-down wins, a released line floats up to the pull-up
	always_comb begin
		pin_level = ~gpio_oe & (ext_val | ~ext_en);
	end
endmodule
